// ### bench/lhrc_limp_load.sv
// partner: pull-up load on the open-drain limp-home pin
module lhrc_limp_load (
   input  wire logic limp_home_n_o,
   input  wire logic limp_home_n_oe,
   output wire logic limp_pin
);
   timeunit 1ns;
   timeprecision 1ns;
   // a released pin sits at the pull-up level, never the last value
   assign limp_pin = limp_home_n_oe ? limp_home_n_o : 1'h1;
endmodule

// ### bench/lhrc_sva.sv
// checker: port assertions for the limp-home supervisor
module lhrc_sva (
   input wire logic       core_clk,
   input wire logic       rst,
   input wire logic       reset_mode,
   input wire logic       overtemp,
   input wire logic       forced_normal_control,
   input wire logic       reg_wr,
   input wire logic [6:0] reg_addr,
   input wire logic [7:0] reg_wdata,
   input wire logic [7:0] reg_rdata,
   input wire logic       limp_home_n_o,
   input wire logic       limp_home_n_oe
);
   timeunit 1ns;
   timeprecision 1ns;
   logic wa;
   logic wc;
   assign wa = reg_wr && reg_addr == 7'h02;
   assign wc = wa && !reg_wdata[2];
   default clocking @(posedge core_clk);
   endclocking
   default disable iff (rst);
   AST_OD_LOW: assert property (!limp_home_n_o)
      else $error("pin data high");
   AST_WR_SET: assert property (wa && reg_wdata[2] &&
      !forced_normal_control |=> limp_home_n_oe) else $error("set lost");
   // hardware set sources held off so only the write decides
   AST_WR_CLR: assert property (wc && !reset_mode && !overtemp
      |=> !limp_home_n_oe) else $error("clear lost");
   AST_FN_OFF: assert property (forced_normal_control
      |=> !limp_home_n_oe) else $error("pin low in fn");
   AST_FN_RD: assert property (forced_normal_control [*3]
      |-> !reg_rdata[2]) else $error("bit set in fn");
   AST_UNMAP: assert property (reg_addr != 7'h02
      |=> reg_rdata == 8'h00) else $error("unmapped data");
   AST_OE_FALL: assert property ($fell(limp_home_n_oe) |->
      $past(rst) || $past(forced_normal_control) || $past(wc))
      else $error("pin freed");
   AST_WR_RD: assert property (wa && !reset_mode ##1
      reg_addr == 7'h02 && !reset_mode |=>
      reg_rdata[1:0] == $past(reg_wdata[1:0], 2)) else $error("readback");
endmodule
bind lhrc_limp_home_reset_counter lhrc_sva lhrc_sva_i (.*);

// ### bench/testbench.sv
// testbench: scenario run for the limp-home supervisor
module testbench;
   timeunit 1ns;
   timeprecision 1ns;
   localparam int L = 8;
   logic       core_clk = 1'h0;
   logic       rst = 1'h1;
   logic       reset_mode = 1'h0;
   logic       overtemp = 1'h0;
   logic       forced_normal_control = 1'h0;
   logic       reg_wr = 1'h0;
   logic [6:0] reg_addr = 7'h02;
   logic [7:0] reg_wdata = 8'h00;
   logic [7:0] reg_rdata;
   logic       limp_home_n_o;
   logic       limp_home_n_oe;
   logic       limp_pin;
   int         err_total = 0;
   int         checks = 0;
   int         cyc = 0;
   lhrc_limp_home_reset_counter #(.LIMP_DELAY_CYC(L))
      lhrc_limp_home_reset_counter_i (.*);
   lhrc_limp_load lhrc_limp_load_i (.*);
   initial forever #50 core_clk = ~core_clk;
   always @(posedge core_clk) begin
      cyc++;
      if (cyc == 1000) begin
         err_total++;
         close_out;
      end
   end
   task close_out;
      $display("checks %0d err_total %0d", checks, err_total);
      if (err_total == 0 && checks > 0)
         $display("ALL TESTS PASSED");
      else
         $display("TESTS FAILED");
      $finish;
   endtask
   task chk(input logic [7:0] s, e, input string n);
      checks++;
      if (s !== e) begin
         err_total++;
         $display("ERROR %s exp %h seen %h", n, e, s);
      end
   endtask
   task wr(input logic [7:0] d);
      @(negedge core_clk);
      reg_wr = 1'h1;
      reg_wdata = d;
      @(negedge core_clk);
      reg_wr = 1'h0;
   endtask
   task rd(input logic [6:0] a, input logic [7:0] e);
      reg_addr = a;
      repeat (2) @(negedge core_clk);
      chk(reg_rdata, e, "rdata");
      chk({7'h00, limp_pin}, {7'h00, ~e[2]}, "pin");
      reg_addr = 7'h02;
   endtask
   task ent;
      @(negedge core_clk);
      reset_mode = 1'h1;
      @(negedge core_clk);
      reset_mode = 1'h0;
   endtask
   task t_count;
      rd(7'h02, 8'h00);
      for (int i = 1; i < 4; i++) begin
         ent;
         rd(7'h02, 8'(i));
      end
      ent;
      rd(7'h02, 8'h04);
      wr(8'h00);
      rd(7'h02, 8'h00);
   endtask
   task t_hold(input logic ot);
      @(negedge core_clk);
      overtemp = ot;
      reset_mode = !ot;
      repeat (L) @(negedge core_clk);
      chk({7'h00, limp_pin}, 8'h01, "early");
      repeat (2) @(negedge core_clk);
      chk({7'h00, limp_pin}, 8'h00, "late");
      overtemp = 1'h0;
      reset_mode = 1'h0;
      wr(8'h00);
   endtask
   task t_race;
      wr(8'h03);
      @(negedge core_clk);
      reset_mode = 1'h1;
      reg_wr = 1'h1;
      reg_wdata = 8'h00;
      @(negedge core_clk);
      reset_mode = 1'h0;
      reg_wr = 1'h0;
      rd(7'h02, 8'h04);
   endtask
   task t_fn;
      wr(8'h06);
      rd(7'h02, 8'h06);
      forced_normal_control = 1'h1;
      ent;
      rd(7'h02, 8'h02);
      rd(7'h05, 8'h00);
      forced_normal_control = 1'h0;
      rd(7'h02, 8'h02);
   endtask
   task t_rst;
      wr(8'h07);
      rd(7'h02, 8'h07);
      rst = 1'h1;
      repeat (2) @(negedge core_clk);
      rst = 1'h0;
      rd(7'h02, 8'h00);
   endtask
   initial begin
      repeat (3) @(negedge core_clk);
      rst = 1'h0;
      t_count;
      t_hold(1'h1);
      t_hold(1'h0);
      t_race;
      t_fn;
      t_rst;
      close_out;
   end
endmodule

// ### design/lhrc_limp_home_reset_counter.sv
// limp-home supervisor: reset event counter and open-drain limp output
//
// Contract
// - limp output is active-low open-drain, floating or pulled low only.
// - control bit at bit 2; 0 floats the output, 1 pulls low.
// - two-bit counter in bits 1:0 increments on each Reset mode entry.
// - entry with counter at 3 sets control bit and wraps counter to 00.
// - software may set the control bit by a register write.
// - output floats again only by software clear, forced normal mode or power-up reset.
// - software may preset the counter; 3 triggers on the next entry.
// - counter is 00 after power-up.
// - overtemperature beyond the limp delay sets the control bit.
// - staying in Reset mode beyond the limp delay sets the control bit.
// - forced normal mode: output floats, counter holds, bit reads 0; here a register write still changes the counter.
// - every sleep exit passes through Reset mode and counts.
module lhrc_limp_home_reset_counter #(
   parameter int LIMP_DELAY_CYC = lhrc_pkg::LIMP_DELAY_CYC
) (
   input  wire logic       core_clk,
   input  wire logic       rst,
   input  wire logic       reset_mode,
   input  wire logic       overtemp,
   input  wire logic       forced_normal_control,
   input  wire logic       reg_wr,
   input  wire logic [6:0] reg_addr,
   input  wire logic [7:0] reg_wdata,
   output logic      [7:0] reg_rdata,
   output logic            limp_home_n_o,
   output logic            limp_home_n_oe
);
   // a zero-length window would let a two-cycle blip force limp home
   if (LIMP_DELAY_CYC < 1) begin
      $error("limp delay must be at least 1 cycle");
   end

   // address decode shared by the write strobe and the read path
   function automatic logic is_fail_safe_control(input logic [6:0] addr);
      return addr == lhrc_pkg::FAIL_SAFE_CONTROL_ADDR;
   endfunction

   logic [1:0] reset_event_counter_reg;
   logic [1:0] reset_event_counter_next;
   logic       limp_home_control_reg;
   logic       limp_home_control_next;
   logic       reset_mode_reg;
   logic       reset_mode_next;
   logic [7:0] rdata_reg;
   logic [7:0] rdata_next;
   logic       entry;
   logic       hw_set;
   logic       sel;

   lhrc_tmr_if ot_tmr ();
   lhrc_tmr_if rm_tmr ();

   // separate timers so each condition has its own persistence window
   assign ot_tmr.run = overtemp && !forced_normal_control;
   assign rm_tmr.run = reset_mode && !forced_normal_control;

   lhrc_persist_timer #(.LIMIT(LIMP_DELAY_CYC)) u_ot_timer (
      .core_clk (core_clk),
      .rst      (rst),
      .tmr      (ot_tmr)
   );

   lhrc_persist_timer #(.LIMIT(LIMP_DELAY_CYC)) u_rm_timer (
      .core_clk (core_clk),
      .rst      (rst),
      .tmr      (rm_tmr)
   );

   assign sel   = reg_wr && is_fail_safe_control(reg_addr);
   // rising edge of reset mode; sleep exits arrive here too
   assign entry = reset_mode && !reset_mode_reg && !forced_normal_control;

   always_comb begin
      reset_mode_next          = reset_mode;
      reset_event_counter_next = reset_event_counter_reg;
      limp_home_control_next   = limp_home_control_reg;
      hw_set                   = 1'h0;
      if (sel) begin
         // software preset of counter and control bit
         reset_event_counter_next =
            reg_wdata[lhrc_pkg::CNT_LSB +: lhrc_pkg::CNT_W];
         limp_home_control_next = reg_wdata[lhrc_pkg::LIMP_CTRL_BIT];
      end
      if (entry) begin
         if (reset_event_counter_reg == lhrc_pkg::CNT_MAX) begin
            hw_set = 1'h1;
         end
         // counting wins over a same-cycle write; wraps 11 to 00
         reset_event_counter_next = reset_event_counter_reg + 2'h1;
      end
      if (ot_tmr.expired || rm_tmr.expired) begin
         hw_set = 1'h1;
      end
      if (hw_set) begin
         limp_home_control_next = 1'h1;
      end
      if (forced_normal_control) begin
         // function disabled: bit held 0, counter changes only by a write
         limp_home_control_next   = 1'h0;
         if (!sel) begin
            reset_event_counter_next = reset_event_counter_reg;
         end
      end
   end

   always_ff @(posedge core_clk) begin
      if (rst) begin
         reset_event_counter_reg <= lhrc_pkg::CNT_RESET;
         limp_home_control_reg   <= lhrc_pkg::LIMP_CTRL_RESET;
         reset_mode_reg          <= 1'h0;
      end else begin
         reset_event_counter_reg <= reset_event_counter_next;
         limp_home_control_reg   <= limp_home_control_next;
         reset_mode_reg          <= reset_mode_next;
      end
   end

   // read data registered; reserved bits read zero
   always_comb begin
      rdata_next = 8'h00;
      if (is_fail_safe_control(reg_addr)) begin
         rdata_next[lhrc_pkg::CNT_LSB +: lhrc_pkg::CNT_W] =
            reset_event_counter_reg;
         rdata_next[lhrc_pkg::LIMP_CTRL_BIT] = limp_home_control_reg;
      end
   end

   always_ff @(posedge core_clk) begin
      if (rst) begin
         rdata_reg <= 8'h00;
      end else begin
         rdata_reg <= rdata_next;
      end
   end

   assign reg_rdata = rdata_reg;

   // open drain: data is always low, only the enable moves
   assign limp_home_n_o  = 1'h0;
   assign limp_home_n_oe = limp_home_control_reg;
endmodule

// ### design/lhrc_persist_timer.sv
// persistence timer: flags a condition held longer than a cycle count
module lhrc_persist_timer #(
   parameter int LIMIT = lhrc_pkg::LIMP_DELAY_CYC
) (
   input  wire logic  core_clk,
   input  wire logic  rst,
   lhrc_tmr_if.timer  tmr
);
   localparam int W = $clog2(LIMIT + 2);
   if (LIMIT < 1) begin
      $error("persist timer limit must be at least 1");
   end

   logic [W-1:0] cnt_reg;
   logic [W-1:0] cnt_next;

   always_comb begin
      cnt_next = cnt_reg;
      if (!tmr.run) begin
         cnt_next = '0;
      end else if (cnt_reg <= W'(LIMIT)) begin
         cnt_next = cnt_reg + W'(1);
      end
   end

   always_ff @(posedge core_clk) begin
      if (rst) begin
         cnt_reg <= '0;
      end else begin
         cnt_reg <= cnt_next;
      end
   end

   // strictly longer than the limit
   assign tmr.expired = tmr.run && (cnt_reg > W'(LIMIT));
endmodule

// ### inc/lhrc_pkg.sv
// package: register map, field layout and timing for the limp-home supervisor
package lhrc_pkg;
   localparam logic [6:0] FAIL_SAFE_CONTROL_ADDR = 7'h02;
   localparam int         CNT_LSB                = 0;
   localparam int         CNT_W                  = 2;
   localparam int         LIMP_CTRL_BIT          = 2;
   localparam logic [1:0] CNT_RESET              = 2'h0;
   localparam logic [1:0] CNT_MAX                = 2'h3;
   localparam logic       LIMP_CTRL_RESET        = 1'h0;
   // limp delay time in microseconds, clock period in nanoseconds
   localparam int         LIMP_DELAY_US          = 100000;
   localparam int         CLK_PERIOD_NS          = 100;
   localparam int         LIMP_DELAY_CYC         =
      (LIMP_DELAY_US * 1000 + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
endpackage

// ### inc/lhrc_tmr_if.sv
// interface: persistence timer request and expiry between the modules
interface lhrc_tmr_if;
   logic run;
   logic expired;
   modport owner (output run, input expired);
   modport timer (input run, output expired);
endinterface
